/* verilog/feps_cfg.svh */
// constants for the flash erase/program sequencer host
`ifndef FEPS_CFG_SVH
`define FEPS_CFG_SVH

`define FEPS_CMD_READ_ARRAY 8'hff
`define FEPS_CMD_ERASE_SETUP 8'h20
`define FEPS_CMD_CONFIRM 8'hd0
`define FEPS_CMD_SUSPEND 8'hb0
`define FEPS_CMD_READ_STATUS 8'h70
`define FEPS_CMD_CLEAR_STATUS 8'h50
`define FEPS_CMD_PROG_SETUP 8'h40

`define FEPS_SR_READY 7
`define FEPS_SR_ERASE_ERR 5
`define FEPS_SR_PROG_ERR 4
`define FEPS_SR_VPP_ERR 3

`define FEPS_AXI_AW 8
`define FEPS_OFF_CMD 8'h00
`define FEPS_OFF_ADDR 8'h04
`define FEPS_OFF_WDATA 8'h08
`define FEPS_OFF_STATUS 8'h0c
`define FEPS_OFF_RDATA 8'h10

`define FEPS_ST_SR_HI 7
`define FEPS_ST_BUSY 8
`define FEPS_ST_SUSP 9
`define FEPS_ST_DONE 10
`define FEPS_ST_REFUSED 11
`define FEPS_ST_TMO 12
`define FEPS_OP_HI 2

`define FEPS_RESP_OKAY 2'h0
`define FEPS_RESP_SLVERR 2'h2

`define FEPS_CLK_NS 25
`define FEPS_PROG_TO_NS 1500000
`define FEPS_PROG_TO_CYC \
  ((`FEPS_PROG_TO_NS + `FEPS_CLK_NS - 1) / `FEPS_CLK_NS)
`define FEPS_PH_CYC 3
`define FEPS_BLK_LSB 12

`endif

/* verilog/feps_pkg.sv */
// types shared by the flash sequencer host
package feps_pkg;

  typedef enum logic [8:0] {
    FEPS_ST_IDLE = 9'h001,
    FEPS_ST_CMD1 = 9'h002,
    FEPS_ST_CMD2 = 9'h004,
    FEPS_ST_RS = 9'h008,
    FEPS_ST_POLL = 9'h010,
    FEPS_ST_CLR = 9'h020,
    FEPS_ST_RA = 9'h040,
    FEPS_ST_ARR = 9'h080,
    FEPS_ST_SUSP = 9'h100
  } feps_state_t;

  typedef enum logic [2:0] {
    FEPS_OP_NONE = 3'h0,
    FEPS_OP_ERASE = 3'h1,
    FEPS_OP_PROG = 3'h2,
    FEPS_OP_SUSPEND = 3'h3,
    FEPS_OP_RESUME = 3'h4,
    FEPS_OP_READ = 3'h5,
    FEPS_OP_STATUS = 3'h6
  } feps_op_t;

  function automatic logic [31:0] feps_mask(input logic [3:0] strb);
    feps_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction : feps_mask

endpackage : feps_pkg

/* verilog/feps_host.sv */
// host controller driving a parallel flash erase/program sequencer
//
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "feps_cfg.svh"

module feps_host
  import feps_pkg::*;
#(
  parameter int AW = 17,
  parameter int DW = 16,
  parameter int BLK_LSB = `FEPS_BLK_LSB,
  parameter int PROG_TO_CYC = `FEPS_PROG_TO_CYC
)
(
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, low active
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [`FEPS_AXI_AW-1:0] awaddr, // write address
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write byte strobes
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  output logic [1:0] bresp, // write response
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  input wire logic [`FEPS_AXI_AW-1:0] araddr, // read address
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic [AW-1:0] fl_addr, // flash address
  input wire logic [DW-1:0] fl_dq_in, // flash data from pins
  output logic [DW-1:0] fl_dq_out, // flash data to pins
  output logic fl_dq_oe, // flash data drive enable
  output logic fl_ce_n, // flash chip enable, low active
  output logic fl_oe_n, // flash output enable, low active
  output logic fl_we_n // flash write enable, low active
);

  localparam int TW = $clog2(PROG_TO_CYC + 1);
  localparam logic [7:0] PH_LAST = 8'(`FEPS_PH_CYC - 1);
  localparam logic [TW-1:0] TO_LIM = TW'(PROG_TO_CYC);

  typedef struct packed {
    feps_state_t st;
    logic [1:0] ph;
    logic [7:0] sub;
    feps_op_t op;
    logic susp;
    logic pend_susp;
    logic [AW-1:0] addr;
    logic [AW-1:0] eaddr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;
    logic [DW-1:0] cap;
    logic [DW-1:0] sync1;
    logic [DW-1:0] sync2;
    logic [7:0] sr;
    logic done;
    logic refused;
    logic tmo;
    logic [TW-1:0] tcnt;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic dq_oe;
    logic [DW-1:0] dq_out;
    logic [AW-1:0] fa;
    logic aw_got;
    logic w_got;
    logic [`FEPS_AXI_AW-1:0] awaddr;
    logic [31:0] wd;
    logic [3:0] ws;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdat;
    logic [1:0] rresp;
  } feps_regs_t;

  feps_regs_t s;
  feps_regs_t nxt;

  logic busy;
  logic bdone;
  logic cmd_go;
  feps_op_t cmd_v;
  logic [31:0] m;
  logic [31:0] stv;
  logic is_rd;
  logic in_blk;

  assign awready = !s.aw_got && !s.bvalid;
  assign wready = !s.w_got && !s.bvalid;
  assign arready = !s.rvalid;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign rvalid = s.rvalid;
  assign rdata = s.rdat;
  assign rresp = s.rresp;
  assign fl_addr = s.fa;
  assign fl_dq_out = s.dq_out;
  assign fl_dq_oe = s.dq_oe;
  assign fl_ce_n = s.ce_n;
  assign fl_oe_n = s.oe_n;
  assign fl_we_n = s.we_n;

  always_comb
  begin
    nxt = s;
    cmd_go = 1'b0;
    cmd_v = FEPS_OP_NONE;
    m = '0;
    stv = '0;
    is_rd = 1'b0;
    busy = !(s.st == FEPS_ST_IDLE || s.st == FEPS_ST_SUSP);
    bdone = busy && s.ph == 2'h3 && s.sub == PH_LAST;
    in_blk = s.addr[AW-1:BLK_LSB] == s.eaddr[AW-1:BLK_LSB];
    // pin data reaches logic only through the second flop
    nxt.sync1 = fl_dq_in;
    nxt.sync2 = s.sync1;

    stv[`FEPS_ST_SR_HI:0] = s.sr;
    stv[`FEPS_ST_BUSY] = busy;
    stv[`FEPS_ST_SUSP] = s.susp;
    stv[`FEPS_ST_DONE] = s.done;
    stv[`FEPS_ST_REFUSED] = s.refused;
    stv[`FEPS_ST_TMO] = s.tmo;

    if (s.bvalid && bready)
      nxt.bvalid = 1'b0;
    if (awvalid && awready)
    begin
      nxt.aw_got = 1'b1;
      nxt.awaddr = awaddr;
    end
    if (wvalid && wready)
    begin
      nxt.w_got = 1'b1;
      nxt.wd = wdata;
      nxt.ws = wstrb;
    end
    if (nxt.aw_got && nxt.w_got)
    begin
      nxt.aw_got = 1'b0;
      nxt.w_got = 1'b0;
      nxt.bvalid = 1'b1;
      nxt.bresp = `FEPS_RESP_OKAY;
      m = feps_mask(nxt.ws);
      case (nxt.awaddr)
        `FEPS_OFF_CMD:
        begin
          cmd_go = nxt.ws[0];
          cmd_v = feps_op_t'(nxt.wd[`FEPS_OP_HI:0]);
        end
        `FEPS_OFF_ADDR:
          nxt.addr = AW'((32'(s.addr) & ~m) | (nxt.wd & m));
        `FEPS_OFF_WDATA:
          nxt.wdata = DW'((32'(s.wdata) & ~m) | (nxt.wd & m));
        `FEPS_OFF_STATUS:
        begin
          // write one to clear; hardware sets below take priority
          if (nxt.wd[`FEPS_ST_DONE] && m[`FEPS_ST_DONE])
            nxt.done = 1'b0;
          if (nxt.wd[`FEPS_ST_REFUSED] && m[`FEPS_ST_REFUSED])
            nxt.refused = 1'b0;
          if (nxt.wd[`FEPS_ST_TMO] && m[`FEPS_ST_TMO])
            nxt.tmo = 1'b0;
        end
        default:
          nxt.bresp = `FEPS_RESP_SLVERR;
      endcase
    end

    if (arvalid && arready)
    begin
      nxt.rvalid = 1'b1;
      nxt.rresp = `FEPS_RESP_OKAY;
      case (araddr)
        `FEPS_OFF_CMD: nxt.rdat = 32'(s.op);
        `FEPS_OFF_ADDR: nxt.rdat = 32'(s.addr);
        `FEPS_OFF_WDATA: nxt.rdat = 32'(s.wdata);
        `FEPS_OFF_STATUS: nxt.rdat = stv;
        `FEPS_OFF_RDATA: nxt.rdat = 32'(s.rdata);
        default:
        begin
          nxt.rdat = '0;
          nxt.rresp = `FEPS_RESP_SLVERR;
        end
      endcase
    end
    else if (s.rvalid && rready)
      nxt.rvalid = 1'b0;

    // bus cycle engine: four phases of PH_CYC clocks each
    if (busy)
    begin
      if (s.sub == PH_LAST)
      begin
        nxt.sub = '0;
        nxt.ph = s.ph + 2'h1;
      end
      else
        nxt.sub = s.sub + 8'h1;
    end
    if (busy && s.ph == 2'h2 && s.sub == PH_LAST)
      nxt.cap = s.sync2;
    if (s.st == FEPS_ST_POLL && s.tcnt != TO_LIM)
      nxt.tcnt = s.tcnt + TW'(1);

    case (s.st)
      FEPS_ST_IDLE:
        if (cmd_go)
        begin
          if (cmd_v == FEPS_OP_ERASE || cmd_v == FEPS_OP_PROG ||
              cmd_v == FEPS_OP_READ || cmd_v == FEPS_OP_STATUS)
          begin
            nxt.op = cmd_v;
            nxt.st = FEPS_ST_CMD1;
          end
          else
            nxt.refused = 1'b1;
        end
      FEPS_ST_SUSP:
        if (cmd_go)
        begin
          if ((cmd_v == FEPS_OP_READ && !in_blk) ||
              cmd_v == FEPS_OP_STATUS || cmd_v == FEPS_OP_RESUME)
          begin
            nxt.op = cmd_v;
            nxt.st = FEPS_ST_CMD1;
          end
          else
            nxt.refused = 1'b1;
        end
      FEPS_ST_CMD1:
        if (bdone)
        begin
          case (s.op)
            FEPS_OP_ERASE, FEPS_OP_PROG: nxt.st = FEPS_ST_CMD2;
            FEPS_OP_SUSPEND: nxt.st = FEPS_ST_RS;
            FEPS_OP_RESUME:
            begin
              nxt.susp = 1'b0;
              nxt.st = FEPS_ST_RS;
            end
            FEPS_OP_READ: nxt.st = FEPS_ST_ARR;
            default: nxt.st = FEPS_ST_POLL;
          endcase
          nxt.tcnt = '0;
        end
      FEPS_ST_CMD2:
        if (bdone)
        begin
          if (s.op == FEPS_OP_ERASE)
            nxt.eaddr = s.addr;
          nxt.st = FEPS_ST_RS;
        end
      FEPS_ST_RS:
        if (bdone)
        begin
          nxt.tcnt = '0;
          nxt.st = FEPS_ST_POLL;
        end
      FEPS_ST_POLL:
      begin
        if (cmd_go)
        begin
          if (cmd_v == FEPS_OP_SUSPEND &&
              (s.op == FEPS_OP_ERASE || s.op == FEPS_OP_RESUME))
            nxt.pend_susp = 1'b1;
          else
            nxt.refused = 1'b1;
        end
        if (bdone)
        begin
          nxt.sr = s.cap[7:0];
          if (s.op == FEPS_OP_STATUS)
            nxt.st = FEPS_ST_RA;
          else if (s.cap[`FEPS_SR_READY])
          begin
            if (s.op == FEPS_OP_SUSPEND)
            begin
              nxt.susp = 1'b1;
              nxt.done = 1'b1;
              nxt.st = FEPS_ST_SUSP;
            end
            else
              nxt.st = FEPS_ST_CLR;
          end
          else if (s.pend_susp || (cmd_go && cmd_v == FEPS_OP_SUSPEND &&
                   (s.op == FEPS_OP_ERASE || s.op == FEPS_OP_RESUME)))
          begin
            nxt.pend_susp = 1'b0;
            nxt.op = FEPS_OP_SUSPEND;
            nxt.st = FEPS_ST_CMD1;
          end
          else if (s.op == FEPS_OP_PROG && s.tcnt == TO_LIM)
          begin
            nxt.tmo = 1'b1;
            nxt.st = FEPS_ST_CLR;
          end
        end
      end
      FEPS_ST_CLR:
        if (bdone)
          nxt.st = FEPS_ST_RA;
      FEPS_ST_RA:
        if (bdone)
        begin
          nxt.done = 1'b1;
          nxt.st = s.susp ? FEPS_ST_SUSP : FEPS_ST_IDLE;
        end
      FEPS_ST_ARR:
        if (bdone)
        begin
          nxt.rdata = s.cap;
          nxt.done = 1'b1;
          nxt.st = s.susp ? FEPS_ST_SUSP : FEPS_ST_IDLE;
        end
      default:
        nxt.st = FEPS_ST_IDLE;
    endcase

    // pins follow the next state so they line up with the phase count
    is_rd = nxt.st == FEPS_ST_POLL || nxt.st == FEPS_ST_ARR;
    nxt.fa = s.addr;
    nxt.dq_out = DW'(`FEPS_CMD_READ_ARRAY);
    case (nxt.st)
      FEPS_ST_CMD1:
        case (nxt.op)
          FEPS_OP_ERASE: nxt.dq_out = DW'(`FEPS_CMD_ERASE_SETUP);
          FEPS_OP_PROG: nxt.dq_out = DW'(`FEPS_CMD_PROG_SETUP);
          FEPS_OP_SUSPEND:
          begin
            nxt.dq_out = DW'(`FEPS_CMD_SUSPEND);
            nxt.fa = s.eaddr;
          end
          FEPS_OP_RESUME:
          begin
            nxt.dq_out = DW'(`FEPS_CMD_CONFIRM);
            nxt.fa = s.eaddr;
          end
          FEPS_OP_STATUS: nxt.dq_out = DW'(`FEPS_CMD_READ_STATUS);
          default: nxt.dq_out = DW'(`FEPS_CMD_READ_ARRAY);
        endcase
      FEPS_ST_CMD2:
        nxt.dq_out = (nxt.op == FEPS_OP_ERASE) ?
                     DW'(`FEPS_CMD_CONFIRM) : s.wdata;
      FEPS_ST_RS: nxt.dq_out = DW'(`FEPS_CMD_READ_STATUS);
      FEPS_ST_CLR: nxt.dq_out = DW'(`FEPS_CMD_CLEAR_STATUS);
      default: nxt.dq_out = DW'(`FEPS_CMD_READ_ARRAY);
    endcase
    // chip enable high outside cycles gives standby while suspended
    nxt.ce_n = nxt.st == FEPS_ST_IDLE || nxt.st == FEPS_ST_SUSP;
    nxt.dq_oe = !nxt.ce_n && !is_rd;
    nxt.we_n = !(nxt.dq_oe && (nxt.ph == 2'h1 || nxt.ph == 2'h2));
    nxt.oe_n = !(!nxt.ce_n && is_rd && (nxt.ph == 2'h1 || nxt.ph == 2'h2));
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s <= '0;
      s.st <= FEPS_ST_IDLE;
      s.ce_n <= 1'b1;
      s.oe_n <= 1'b1;
      s.we_n <= 1'b1;
    end
    else
      s <= nxt;
  end

endmodule : feps_host

/* verif/feps_flash_model.sv */
// behavioural flash device for the host controller bench
`timescale 1ns/100ps
module feps_flash_model (
  input wire logic [16:0] a, // address pins
  input wire logic [15:0] d, // data from host
  input wire logic ce_n, // chip enable
  input wire logic oe_n, // output enable
  input wire logic we_n, // write enable
  input wire logic vpp_ok, // supply in limits
  input wire logic fail, // operation fails
  input wire logic [9:0] polls, // busy length in reads
  output logic [15:0] q, // data to host
  output int viol // host misuse count
);
  logic [7:0] sr = 8'h80;
  logic stat = 0, susp = 0, sreq = 0, ers = 0, esu = 0, psu = 0;
  logic [4:0] blk = 5'h1f, nblk = 5'h1f;
  logic [15:0] val, last = 0;
  int busy = 0;
  initial viol = 0;
  assign val = stat ? {8'h00, sr}
    : (a[16:12] == blk ? 16'hffff : a[15:0] ^ 16'h5a5a);
  // released bus shows the inverse so no stale value passes
  assign q = (!ce_n && !oe_n) ? val : ~last;
  task automatic start(input logic e);
    ers = e;
    stat = 1;
    if (!vpp_ok)
      sr = e ? 8'ha8 : 8'h98;
    else
    begin
      busy = polls;
      sr[7] = 0;
    end
  endtask : start
  always @(posedge we_n) if (!ce_n)
  begin
    if (esu)
    begin
      esu = 0;
      viol += (d[7:0] != 8'hd0);
      nblk = a[16:12];
      start(1);
    end
    else if (psu)
    begin
      psu = 0;
      start(0);
    end
    else if (busy > 0 && !susp)
      sreq = sreq || (ers && d[7:0] == 8'hb0);
    else if (susp && d[7:0] == 8'hd0)
    begin
      susp = 0;
      stat = 1;
      sr[7] = 0;
    end
    else if (!susp || d[7:0] == 8'hff || d[7:0] == 8'h70)
      case (d[7:0])
        8'hff: stat = 0;
        8'h70: stat = 1;
        8'h50: sr[5:3] = 3'h0;
        8'h20: esu = 1;
        8'h40: psu = 1;
        default: ;
      endcase
  end
  always @(posedge oe_n)
  begin
    last = val;
    if (!ce_n && stat && busy > 0 && !susp)
    begin
      busy--;
      if (sreq)
      begin
        sreq = 0;
        susp = 1;
        sr[7] = 1;
      end
      else if (busy == 0)
      begin
        sr[7] = 1;
        if (ers && !fail) blk = nblk;
        sr[5] = ers && fail;
        sr[4] = !ers && fail;
      end
    end
    viol += (susp && !stat && a[16:12] == nblk);
  end
endmodule : feps_flash_model

/* verif/feps_host_checker.sv */
// port assertions for the flash sequencer host
`timescale 1ns/100ps
module feps_host_checker
  import feps_pkg::*;
#(
  parameter int AW = 17,
  parameter int DW = 16
)
(
  input wire logic aclk, // clock
  input wire logic aresetn, // reset
  input wire logic awvalid, // aw valid
  input wire logic awready, // aw ready
  input wire logic wvalid, // w valid
  input wire logic wready, // w ready
  input wire logic bvalid, // b valid
  input wire logic bready, // b ready
  input wire logic [1:0] bresp, // b resp
  input wire logic arvalid, // ar valid
  input wire logic arready, // ar ready
  input wire logic rvalid, // r valid
  input wire logic rready, // r ready
  input wire logic [31:0] rdata, // r data
  input wire logic [AW-1:0] fl_addr, // flash address
  input wire logic [DW-1:0] fl_dq_out, // flash data out
  input wire logic fl_dq_oe, // data drive
  input wire logic fl_ce_n, // chip enable
  input wire logic fl_oe_n, // output enable
  input wire logic fl_we_n // write enable
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_reset_idle: assert property ($rose(aresetn) |->
    fl_ce_n && fl_we_n && fl_oe_n && !fl_dq_oe)
    else $error("flash pins active after reset");
  chk_strobe_excl: assert property (fl_we_n || fl_oe_n)
    else $error("read and write strobes together");
  chk_write_sel: assert property (!fl_we_n |-> !fl_ce_n && fl_dq_oe)
    else $error("write strobe without chip enable");
  chk_we_width: assert property ($fell(fl_we_n) |->
    (!fl_we_n)[*6] ##1 fl_we_n) else $error("write strobe width");
  chk_oe_width: assert property ($fell(fl_oe_n) |->
    (!fl_oe_n)[*6] ##1 fl_oe_n) else $error("read strobe width");
  chk_addr_hold: assert property (!fl_we_n && !$fell(fl_we_n) |->
    $stable(fl_addr) && $stable(fl_dq_out)) else $error("write unstable");
  chk_b_hold: assert property (bvalid && !bready |=>
    bvalid && $stable(bresp)) else $error("write response dropped");
  chk_r_hold: assert property (rvalid && !rready |=>
    rvalid && $stable(rdata)) else $error("read data dropped");
  chk_b_answer: assert property (awvalid && awready && wvalid && wready
    |=> bvalid) else $error("write response late");
  chk_r_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read data late");
  cover property (!fl_we_n && fl_dq_out[7:0] == 8'h20);
  cover property (!fl_we_n && fl_dq_out[7:0] == 8'hb0);
  cover property (!fl_we_n && fl_dq_out[7:0] == 8'hd0);
endmodule : feps_host_checker
bind feps_host feps_host_checker #(.AW(AW), .DW(DW)) chk_u (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
  .bresp(bresp), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
  .rready(rready), .rdata(rdata), .fl_addr(fl_addr),
  .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe), .fl_ce_n(fl_ce_n),
  .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n));

/* verif/feps_host_tb_top.sv */
// random and directed test of the flash sequencer host
`timescale 1ns/100ps
module feps_host_tb_top
  import feps_pkg::*;
;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, vpp_ok = 1, fail = 0;
  logic awready, wready, bvalid, arready, rvalid, oe, ce_n, oe_n, we_n;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rd, r, seed = 32'd45919;
  logic [3:0] wstrb = 0;
  logic [1:0] bresp, rresp, rr, br;
  logic [16:0] fl_addr;
  logic [15:0] dq_out, dq_in;
  logic [9:0] polls = 10'd3;
  logic [4:0] eblk = 5'h1f;
  logic [31:0] corner [4] = '{32'h01530041, 32'h00a20040,
    32'h0031000d, 32'h0074004d};
  int viol, err_count = 0, tests_run = 0, cyc = 0;
  always #12.5 aclk = ~aclk;
  feps_host #(.PROG_TO_CYC(200)) dut_u (.aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .fl_addr(fl_addr), .fl_dq_in(dq_in),
    .fl_dq_out(dq_out), .fl_dq_oe(oe), .fl_ce_n(ce_n), .fl_oe_n(oe_n),
    .fl_we_n(we_n));
  feps_flash_model fl_u (.a(fl_addr), .d(dq_out), .ce_n(ce_n),
    .oe_n(oe_n), .we_n(we_n), .vpp_ok(vpp_ok), .fail(fail),
    .polls(polls), .q(dq_in), .viol(viol));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [7:0] sr_exp(input logic e, v, f);
    if (!v) return e ? 8'ha8 : 8'h98;
    return f ? (e ? 8'ha0 : 8'h90) : 8'h80;
  endfunction : sr_exp
  function automatic logic [15:0] arr_exp(input logic [16:0] a);
    return a[16:12] == eblk ? 16'hffff : a[15:0] ^ 16'h5a5a;
  endfunction : arr_exp
  task automatic chk(input logic [31:0] got, exp, input string m);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ga, gw;
    ga = 0;
    gw = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hf;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!(ga && gw))
    begin
      @(negedge aclk);
      ga = ga || awready;
      gw = gw || wready;
      @(posedge aclk);
      if (ga) awvalid <= 0;
      if (gw) wvalid <= 0;
    end
    do @(negedge aclk); while (!bvalid);
    br = bresp;
    @(posedge aclk);
    bready <= 0;
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 0;
    do @(negedge aclk); while (!rvalid);
    rd = rdata;
    rr = rresp;
    @(posedge aclk);
    rready <= 0;
  endtask : rdr
  // waits on one status bit; the cycle ceiling catches a hang
  task automatic op(input logic [2:0] o, input logic [16:0] ad,
    input int b, input logic v);
    wr(8'h0c, 32'h1c00);
    wr(8'h04, {15'h0, ad});
    wr(8'h08, rnd());
    wr(8'h00, {29'h0, o});
    do rdr(8'h0c); while (rd[b] !== v);
  endtask : op
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      $display("BAD %0t timeout", $time);
      err_count++;
      tally_and_finish;
    end
  end
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rdr(8'h0c);
    chk(rd[12:8], 0, "status flags at reset");
    rdr(8'h14);
    chk(rr, 2'h2, "unmapped read");
    wr(8'h14, 32'h0);
    chk(br, 2'h2, "unmapped write");
    wr(8'h04, 32'h00012345);
    chk(br, 2'h0, "address write");
    rdr(8'h04);
    chk(rd, 32'h00012345, "address readback");
    wr(8'h08, 32'h0000a5c3);
    rdr(8'h08);
    chk(rd, 32'h0000a5c3, "program data readback");
    op(3'h4, 17'h00000, 11, 1);
    chk(ce_n, 1, "resume refused when idle");
    $display("register test done");
    for (int i = 0; i < 10; i++)
    begin
      r = i < 4 ? corner[i] : rnd();
      vpp_ok <= r[0] | r[1];
      fail <= r[2] & r[3];
      polls <= 10'(r[5:4]) + 10'd1;
      op(r[6] ? 3'h1 : 3'h2, r[24:8], 10, 1);
      chk(rd[7:0], sr_exp(r[6], r[0] | r[1], r[2] & r[3]), "op");
      if (r[6] && (r[0] | r[1]) && !(r[2] & r[3])) eblk = r[24:20];
      op(3'h5, r[24:8], 10, 1);
      rdr(8'h10);
      chk(rd[15:0], arr_exp(r[24:8]), "array read");
      $display("op test %0d done", i);
    end
    vpp_ok <= 1;
    fail <= 0;
    polls <= 10'd40;
    op(3'h1, 17'h0a123, 7, 0);
    op(3'h3, 17'h0a123, 9, 1);
    @(negedge aclk);
    chk(ce_n, 1, "standby while suspended");
    chk(oe, 0, "bus released while suspended");
    op(3'h5, 17'h0a123, 11, 1);
    op(3'h2, 17'h03456, 11, 1);
    op(3'h6, 17'h0a123, 10, 1);
    chk(rd[9:0], 10'h280, "status while suspended");
    op(3'h5, 17'h03456, 10, 1);
    rdr(8'h10);
    chk(rd[15:0], arr_exp(17'h03456), "other block read");
    op(3'h4, 17'h0a123, 10, 1);
    chk(rd[9:0], 10'h080, "resumed erase");
    eblk = 5'h0a;
    op(3'h5, 17'h0a123, 10, 1);
    rdr(8'h10);
    chk(rd[15:0], 16'hffff, "resumed block erased");
    $display("suspend test done");
    polls <= 10'd1000;
    op(3'h2, 17'h01000, 10, 1);
    chk(rd[12], 1, "program timeout");
    chk(viol, 0, "flash misuse");
    $display("timeout test done");
    tally_and_finish;
  end
endmodule : feps_host_tb_top
